// File: core/tpo_consts.vh
// Constants for the timer PWM and one-pulse output block.
// Assumes a single clock domain and plain configuration ports.
`ifndef TPO_CONSTS_VH
`define TPO_CONSTS_VH
`define TPO_OCM_FROZEN   3'h0
`define TPO_OCM_ACTIVE   3'h1
`define TPO_OCM_INACTIVE 3'h2
`define TPO_OCM_TOGGLE   3'h3
`define TPO_OCM_FORCE_LO 3'h4
`define TPO_OCM_FORCE_HI 3'h5
`define TPO_OCM_PWM1     3'h6
`define TPO_OCM_PWM2     3'h7
`define TPO_CMS_EDGE     2'h0
`define TPO_CMS_DOWN     2'h1
`define TPO_CMS_UP       2'h2
`define TPO_CMS_BOTH     2'h3
`define TPO_TS_TI2       3'h6
`define TPO_SMS_TRIGGER  3'h6
`endif

// File: core/tpo_timer.v
// Timer counter with per-channel compare outputs, PWM and one-pulse operation.
// Assumes inputs are synchronous to i_mclk and the trigger is already filtered.
`include "tpo_consts.vh"
`default_nettype none

module tpo_timer #(
  parameter W  = 16,
  parameter NC = 4
) (
  input  wire          i_mclk,
  input  wire          i_resetn,
  input  wire [W-1:0]  i_reload_value,
  input  wire          i_reload_wr,
  input  wire          i_reload_buffer_enable,
  input  wire [W-1:0]  i_counter_wr_value,
  input  wire          i_counter_wr,
  input  wire          i_counter_enable_set,
  input  wire          i_counter_enable_clr,
  input  wire          i_update_generate,
  input  wire [1:0]    i_alignment_select,
  input  wire          i_count_direction,
  input  wire          i_direction_wr,
  input  wire          i_single_pulse_select,
  input  wire [2:0]    i_trigger_source_select,
  input  wire [2:0]    i_slave_mode_select,
  input  wire          i_filtered_input_two,
  input  wire [NC*W-1:0] i_compare_value,
  input  wire [NC-1:0] i_compare_wr,
  input  wire [NC-1:0] i_compare_buffer_enable,
  input  wire [NC*3-1:0] i_compare_output_mode,
  input  wire [NC-1:0] i_fast_compare_enable,
  input  wire [NC-1:0] i_output_polarity,
  input  wire [NC-1:0] i_output_enable,
  output wire [W-1:0]  o_counter_value,
  output wire          o_counter_enable,
  output wire          o_count_direction,
  output wire          o_update_event,
  output wire [NC-1:0] o_compare_flag,
  output wire [NC-1:0] o_reference_waveform,
  output wire [NC-1:0] o_channel_output,
  output wire [NC-1:0] o_channel_output_en
);

  // ----------------------------------------
  // Counter and direction
  // ----------------------------------------
  reg  [W-1:0] cnt_q;
  reg          cen_q;
  reg          dir_q;
  reg  [W-1:0] arr_buf_q;
  reg  [W-1:0] arr_q;
  reg          trig_prev_q;
  reg          uev_q;

  wire         center   = (i_alignment_select != `TPO_CMS_EDGE);

  // ----------------------------------------
  // Trigger selection
  // ----------------------------------------
  // The pin is taken as already filtered, so only its rising edge is detected here.
  wire         trig_sel = (i_trigger_source_select == `TPO_TS_TI2) ?
                          i_filtered_input_two : 1'b0;
  wire         trig     = trig_sel & ~trig_prev_q &
                          (i_slave_mode_select == `TPO_SMS_TRIGGER);
  wire         at_top   = (cnt_q == arr_q);
  wire         at_bot   = (cnt_q == {W{1'b0}});
  wire         wrap     = cen_q & (center ? ((dir_q & at_bot) | (~dir_q & at_top)) :
                                   (dir_q ? at_bot : at_top));
  wire         update_event      = wrap | i_update_generate;
  wire [W-1:0] arr_in   = i_reload_buffer_enable ? arr_buf_q : i_reload_value;
  wire [W-1:0] cnt_up   = cnt_q + {{(W-1){1'b0}}, 1'b1};
  wire [W-1:0] cnt_dn   = cnt_q - {{(W-1){1'b0}}, 1'b1};
  reg  [W-1:0] cnt_d;
  reg          cen_d;
  reg          dir_d;

  // ----------------------------------------
  // Counter next state
  // ----------------------------------------
  always @* begin
    cnt_d = cnt_q;
    cen_d = cen_q;
    dir_d = dir_q;
    // Stop wins over a simultaneous software enable so one pulse stays one pulse.
    if (wrap && i_single_pulse_select) begin
      cen_d = 1'b0;
    end else if (trig || i_counter_enable_set) begin
      cen_d = 1'b1;
    end else if (i_counter_enable_clr) begin
      cen_d = 1'b0;
    end
    if (i_counter_wr) begin
      cnt_d = i_counter_wr_value;
      if (center && (i_counter_wr_value == {W{1'b0}})) begin
        dir_d = 1'b0;
      end else if (center && (i_counter_wr_value == arr_q)) begin
        dir_d = 1'b1;
      end
    end else if (i_update_generate) begin
      cnt_d = (dir_q && !center) ? arr_in : {W{1'b0}};
    end else if (cen_q) begin
      if (center) begin
        if (!dir_q && at_top) begin
          dir_d = 1'b1;
          cnt_d = cnt_dn;
        end else if (dir_q && at_bot) begin
          dir_d = 1'b0;
          cnt_d = cnt_up;
        end else begin
          // The counter starts from whatever direction is held.
          cnt_d = dir_q ? cnt_dn : cnt_up;
        end
      end else if (wrap) begin
        cnt_d = dir_q ? arr_q : {W{1'b0}};
      end else begin
        cnt_d = dir_q ? cnt_dn : cnt_up;
      end
    end
    // Software direction writes count only in edge-aligned mode.
    if (i_direction_wr && !center && !i_counter_wr) begin
      dir_d = i_count_direction;
    end
  end

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q       <= {W{1'b0}};
      cen_q       <= 1'b0;
      dir_q       <= 1'b0;
      trig_prev_q <= 1'b0;
      uev_q       <= 1'b0;
    end else begin
      cnt_q       <= cnt_d;
      cen_q       <= cen_d;
      dir_q       <= dir_d;
      trig_prev_q <= trig_sel;
      uev_q       <= update_event;
    end
  end

  // ----------------------------------------
  // Reload buffer and shadow
  // ----------------------------------------
  // Both copies leave reset at all ones, so a start before setup does not wrap at once.
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      arr_buf_q <= {W{1'b1}};
      arr_q     <= {W{1'b1}};
    end else begin
      if (i_reload_wr) begin
        arr_buf_q <= i_reload_value;
      end
      if (!i_reload_buffer_enable) begin
        arr_q <= i_reload_value;
      end else if (update_event) begin
        arr_q <= arr_in;
      end
    end
  end

  assign o_counter_value   = cnt_q;
  assign o_counter_enable  = cen_q;
  assign o_count_direction = dir_q;
  assign o_update_event    = uev_q;

  // ----------------------------------------
  // Compare channels
  // ----------------------------------------
  genvar c;
  generate
    for (c = 0; c < NC; c = c + 1) begin : g_ch
      reg  [W-1:0] ccr_buf_q;
      reg  [W-1:0] ccr_q;
      reg          ref_q;
      reg          cmp_prev_q;
      reg  [2:0]   mode_prev_q;
      reg          flag_q;
      reg          out_q;
      reg          oen_q;
      wire [2:0]   mode  = i_compare_output_mode[c*3 +: 3];
      wire         pwm   = (mode == `TPO_OCM_PWM1) || (mode == `TPO_OCM_PWM2);
      wire [W-1:0] wval  = i_compare_value[c*W +: W];
      // Mode 1 level: up-count high below compare; down-count high unless above it.
      wire         lvl1  = dir_q ? (cnt_q <= ccr_q) : (cnt_q < ccr_q);
      wire         big   = (ccr_q > arr_q);
      wire         m1    = big ? 1'b1 : lvl1;
      wire         lvl   = (mode == `TPO_OCM_PWM2) ? ~m1 : m1;
      wire         match = (cnt_q == ccr_q) & cen_q;
      reg          flag_dir;
      reg          ref_d;

      // ----------------------------------------
      // Compare flag direction filter
      // ----------------------------------------
      always @* begin
        flag_dir = 1'b1;
        case (i_alignment_select)
          `TPO_CMS_EDGE: flag_dir = 1'b1;
          `TPO_CMS_DOWN: flag_dir = dir_q;
          `TPO_CMS_UP:   flag_dir = ~dir_q;
          `TPO_CMS_BOTH: flag_dir = 1'b1;
          default:       flag_dir = 1'b1;
        endcase
      end

      // ----------------------------------------
      // Reference waveform next state
      // ----------------------------------------
      always @* begin
        ref_d = ref_q;
        if (pwm && trig && i_fast_compare_enable[c]) begin
          // Level of the first match after start, taken without comparing.
          ref_d = (mode == `TPO_OCM_PWM2);
        end else if (pwm) begin
          if ((lvl != cmp_prev_q) || (mode_prev_q == `TPO_OCM_FROZEN)) begin
            ref_d = lvl;
          end
        end else begin
          case (mode)
            `TPO_OCM_FROZEN:   ref_d = ref_q;
            `TPO_OCM_ACTIVE:   ref_d = match ? 1'b1 : ref_q;
            `TPO_OCM_INACTIVE: ref_d = match ? 1'b0 : ref_q;
            `TPO_OCM_TOGGLE:   ref_d = match ? ~ref_q : ref_q;
            `TPO_OCM_FORCE_LO: ref_d = 1'b0;
            `TPO_OCM_FORCE_HI: ref_d = 1'b1;
            default:           ref_d = ref_q;
          endcase
        end
        // After a single pulse stops at the wrap the mode 2 level is low again.
        if (wrap && i_single_pulse_select && !dir_q && !center && pwm) begin
          ref_d = (mode == `TPO_OCM_PWM1);
        end
      end

      always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
          ccr_buf_q   <= {W{1'b0}};
          ccr_q       <= {W{1'b0}};
          ref_q       <= 1'b0;
          cmp_prev_q  <= 1'b0;
          mode_prev_q <= `TPO_OCM_FROZEN;
          flag_q      <= 1'b0;
        end else begin
          mode_prev_q <= mode;
          cmp_prev_q  <= lvl;
          flag_q      <= match & flag_dir;
          ref_q       <= ref_d;
          if (i_compare_wr[c]) begin
            ccr_buf_q <= wval;
          end
          if (!i_compare_buffer_enable[c]) begin
            ccr_q <= wval;
          end else if (update_event) begin
            ccr_q <= i_compare_wr[c] ? wval : ccr_buf_q;
          end
        end
      end

      // ----------------------------------------
      // Output stage
      // ----------------------------------------
      // Output pin follows the reference through polarity, registered.
      // The extra flop costs one cycle of delay but keeps the pin free of glitches.
      always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
          out_q <= 1'b0;
          oen_q <= 1'b0;
        end else begin
          oen_q <= i_output_enable[c];
          out_q <= i_output_enable[c] & (ref_q ^ i_output_polarity[c]);
        end
      end
      assign o_reference_waveform[c] = ref_q;
      assign o_channel_output[c]     = out_q;
      assign o_channel_output_en[c]  = oen_q;
      assign o_compare_flag[c]       = flag_q;
    end
  endgenerate

endmodule // tpo_timer

`default_nettype wire

// File: tb/tpo_timer_sva.sv
// Checker for channel 0 of the PWM and one-pulse timer.
// Assumes tpo_timer is built with W of 16 and NC of 4.
`default_nettype none
module tpo_timer_sva (
  input wire logic        i_mclk,
  input wire logic        i_resetn,
  input wire logic        i_counter_wr,
  input wire logic        i_counter_enable_set,
  input wire logic        i_counter_enable_clr,
  input wire logic        i_update_generate,
  input wire logic [1:0]  i_alignment_select,
  input wire logic        i_single_pulse_select,
  input wire logic [2:0]  i_trigger_source_select,
  input wire logic [2:0]  i_slave_mode_select,
  input wire logic        i_filtered_input_two,
  input wire logic [63:0] i_compare_value,
  input wire logic [3:0]  i_compare_wr,
  input wire logic [3:0]  i_compare_buffer_enable,
  input wire logic [11:0] i_compare_output_mode,
  input wire logic [3:0]  i_fast_compare_enable,
  input wire logic [3:0]  i_output_polarity,
  input wire logic [3:0]  i_output_enable,
  input wire logic [15:0] o_counter_value,
  input wire logic        o_counter_enable,
  input wire logic        o_count_direction,
  input wire logic        o_update_event,
  input wire logic [3:0]  o_reference_waveform,
  input wire logic [3:0]  o_channel_output,
  input wire logic [3:0]  o_compare_flag,
  input wire logic [3:0]  o_channel_output_en
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // Tracks the last compare write so comparisons use the live value.
  logic [15:0] ccr_q;
  wire  [2:0]  m0 = i_compare_output_mode[2:0];
  wire         ok = i_slave_mode_select == 3'h6 && i_trigger_source_select == 3'h6;
  wire         st = !i_compare_wr[0] && !i_compare_buffer_enable[0] &&
                    !i_fast_compare_enable[0] && i_alignment_select == 2'h0 && !i_counter_wr &&
                    !i_single_pulse_select;
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) ccr_q <= 16'h0000;
    else if (i_compare_wr[0]) ccr_q <= i_compare_value[15:0];
  end
  chan_out_a: assert property ($past(i_resetn) |-> o_channel_output[0] ==
    $past(i_output_enable[0] & (o_reference_waveform[0] ^ i_output_polarity[0])))
    else $error("channel output does not follow reference");
  upd_pulse_a: assert property (i_update_generate |=> o_update_event)
    else $error("update request gave no update event");
  pwm_one_up_a: assert property ($past(st && m0 == 3'h6 && !o_count_direction) &&
    m0 == 3'h6 && $past(m0, 2) == 3'h6 |-> o_reference_waveform[0] == ($past(o_counter_value) < ccr_q))
    else $error("mode 1 up reference wrong");
  pwm_two_up_a: assert property ($past(st && m0 == 3'h7 && !o_count_direction) &&
    m0 == 3'h7 && $past(m0, 2) == 3'h7 |-> o_reference_waveform[0] == !($past(o_counter_value) < ccr_q))
    else $error("mode 2 up reference wrong");
  pwm_one_down_a: assert property ($past(st && m0 == 3'h6 && o_count_direction) &&
    m0 == 3'h6 && $past(m0, 2) == 3'h6 |-> o_reference_waveform[0] == !($past(o_counter_value) > ccr_q))
    else $error("mode 1 down reference wrong");
  opm_stop_a: assert property ($past(o_counter_enable && i_single_pulse_select && !i_counter_wr &&
    !i_update_generate && i_alignment_select == 2'h0 && !o_count_direction && o_counter_value != 0)
    && o_counter_value == 16'h0000 |-> !o_counter_enable)
    else $error("single pulse counter kept running");
  trig_start_a: assert property ($rose(i_filtered_input_two) && ok && !i_counter_enable_clr
    |=> o_counter_enable) else $error("trigger did not start counter");
  trig_refuse_a: assert property ($rose(i_filtered_input_two) && !ok && !o_counter_enable &&
    !i_counter_enable_set |=> !o_counter_enable) else $error("unselected trigger started counter");
  fast_force_a: assert property ($rose(i_filtered_input_two) && ok && i_fast_compare_enable[0] &&
    m0[2:1] == 2'h3 |=> o_reference_waveform[0] == ($past(m0) == 3'h7))
    else $error("fast enable did not force reference");
  out_en_a: assert property ($past(i_resetn) |->
    o_channel_output_en[0] == $past(i_output_enable[0]))
    else $error("output enable does not follow its control");
  flag_down_a: assert property (o_compare_flag[0] && $past(i_alignment_select) == 2'h1
    |-> $past(o_count_direction)) else $error("down-only flag set while counting up");
  flag_up_a: assert property (o_compare_flag[0] && $past(i_alignment_select) == 2'h2
    |-> !$past(o_count_direction)) else $error("up-only flag set while counting down");
endmodule // tpo_timer_sva
bind tpo_timer tpo_timer_sva u_sva (.*);
`default_nettype wire

// File: tb/tpo_timer_tb.sv
// Self-checking bench for the PWM and one-pulse timer.
// Assumes the checker is bound in and the trigger model drives input two.
`default_nettype none
module tpo_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, rwr = 0, kwr = 0, pwr = 0, ens = 0, enc = 0, ug = 0;
  logic dwr = 0, dir = 0, single_pulse_mode = 0, fire = 0;
  logic [15:0] kv = 16'h0000, ccr = 16'h0000;
  logic [1:0]  cms = 2'h0;
  logic [2:0]  ts = 3'h6, sms = 3'h6, mode = 3'h0;
  logic [3:0]  cbe = 4'h0, fe = 4'h0, pol = 4'h0, oe = 4'hf;
  wire         trig, en, cdir, update_event;
  wire  [15:0] cnt;
  wire  [3:0]  ref_w, cout;
  int err_count = 0, checked = 0, cyc = 0;
  tpo_trig_model u_trig (.i_mclk(clk), .i_fire(fire), .o_trig(trig));
  tpo_timer u_dut (.i_mclk(clk), .i_resetn(rstn), .i_reload_value(16'h0008), .i_reload_wr(rwr),
    .i_reload_buffer_enable(1'b1), .i_counter_wr_value(kv), .i_counter_wr(kwr),
    .i_counter_enable_set(ens), .i_counter_enable_clr(enc), .i_update_generate(ug),
    .i_alignment_select(cms), .i_count_direction(dir), .i_direction_wr(dwr),
    .i_single_pulse_select(single_pulse_mode), .i_trigger_source_select(ts), .i_slave_mode_select(sms),
    .i_filtered_input_two(trig), .i_compare_value({4{ccr}}), .i_compare_wr({4{pwr}}),
    .i_compare_buffer_enable(cbe), .i_compare_output_mode({4{mode}}),
    .i_fast_compare_enable(fe), .i_output_polarity(pol), .i_output_enable(oe),
    .o_counter_value(cnt), .o_counter_enable(en), .o_count_direction(cdir),
    .o_update_event(update_event), .o_compare_flag(), .o_reference_waveform(ref_w),
    .o_channel_output(cout), .o_channel_output_en());
  always #4 clk = ~clk;
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // A stalled test would hang the run, so a cycle ceiling ends it.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run;
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic duty(input int n, output logic [15:0] r, output logic [15:0] c);
    r = 0;
    c = 0;
    repeat (n) begin
      tick(1);
      r += 16'(ref_w[0] === 1'b1);
      c += 16'(cout[0] === 1'b1);
    end
  endtask
  task automatic t_pwm;
    logic [15:0] e [6][5];
    logic [15:0] r, c;
    e = '{'{6, 3, 0, 0, 3}, '{6, 0, 0, 1, 0}, '{6, 0, 0, 0, 0}, '{6, 9, 0, 0, 9},
          '{7, 3, 0, 0, 6}, '{6, 3, 1, 0, 4}};
    pulse(rwr);
    pulse(ug);
    pulse(ens);
    for (int i = 0; i < 6; i++) begin
      mode = 3'h0;
      cbe = {3'h0, e[i][3][0]};
      pol = {3'h0, i[0]};
      dir = e[i][2][0];
      pulse(dwr);
      ccr = e[i][1];
      pulse(pwr);
      mode = e[i][0][2:0];
      tick(12);
      duty(9, r, c);
      chk(r, e[i][4]);
      chk(c, i[0] ? 16'd9 - e[i][4] : e[i][4]);
    end
    oe = 4'h0;
    tick(2);
    chk({12'h000, cout}, 16'h0000);
    oe = 4'hf;
    pulse(enc);
    $display("test pwm done");
  endtask
  task automatic t_center;
    logic [15:0] k [3][2];
    logic [15:0] r, c, r1;
    k = '{'{0, 0}, '{8, 1}, '{20, 1}};
    cms = 2'h1;
    tick(1);
    foreach (k[i]) begin
      kv = k[i][0];
      pulse(kwr);
      chk(cdir, k[i][1]);
      chk(update_event, 0);
    end
    kv = 16'h0005;
    pulse(kwr);
    pulse(ens);
    tick(3);
    chk(cnt < 16'h0005, 1);
    for (int i = 1; i < 4; i++) begin
      cms = i[1:0];
      tick(4);
      duty(32, r, c);
      if (i == 1) r1 = r;
      chk(r, r1);
    end
    pulse(enc);
    cms = 2'h0;
    tick(1);
    dir = 1'b0;
    pulse(dwr);
    $display("test center done");
  endtask
  task automatic t_opm(input logic fast);
    logic [15:0] r;
    int n;
    pol = 4'h0;
    sms = fast ? 3'h6 : 3'h0;
    pulse(fire);
    tick(5);
    chk(en, fast);
    kv = 16'h0000;
    pulse(kwr);
    pulse(enc);
    sms = 3'h6;
    ccr = 16'h0003;
    pulse(pwr);
    mode = 3'h7;
    single_pulse_mode = 1'b1;
    fe = {3'h0, fast};
    tick(2);
    pulse(fire);
    n = 0;
    while (en !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chk(en, 1);
    if (fast) chk(ref_w[0], 1);
    r = 0;
    while (en === 1'b1 && n < 60) begin
      r += 16'(ref_w[0] === 1'b1);
      tick(1);
      n++;
    end
    if (!fast) chk(r, 5);
    tick(8);
    chk({en, cout[0]}, 0);
    $display("test one pulse done");
  endtask
  initial begin
    tick(2);
    rstn = 1'b1;
    tick(1);
    t_pwm;
    t_center;
    t_opm(1'b0);
    t_opm(1'b1);
    complete_run;
  end
endmodule // tpo_timer_tb
`default_nettype wire

// File: tb/tpo_trig_model.sv
// Far-side trigger source that drives the filtered input two pin.
// Assumes the bench asks for a trigger with a one-cycle fire pulse.
`default_nettype none
module tpo_trig_model (
  input  wire logic i_mclk,
  input  wire logic i_fire,
  output var  logic o_trig
);
  timeunit 1ns;
  timeprecision 1ps;
  // The pin is held high a few cycles so the edge is wider than one sample.
  int n = 0;
  initial o_trig = 1'b0;
  always @(posedge i_mclk) begin
    n <= i_fire ? 4 : (n > 0 ? n - 1 : 0);
    o_trig <= i_fire || n > 1;
  end
endmodule // tpo_trig_model
`default_nettype wire
